//--- hw/sppd_pkg.sv
// constants, register map and types for the six-pin port
//
// Function
// - six pins, five bidirectional, one input only
// - direction bit one disables output driver
// - direction bit zero drives output latch bit, except pins five and four in crystal modes
// - input-only pin undriven, direction reads one
// - port read returns sampled pin levels
// - port write updates output latch and re-arms change compare
// - bit set/clear writes are read-modify-write on pins
// - external reset enabled reads input-only pin zero
// - direction still controls drivers when analog
// - analog-selected pins read as zero
// - analog-selected pins raise no change flag
// - analog select leaves digital output unchanged
// - rmw may clear analog output latch bit
// - bits seven and six read zero
// - crystal modes read direction five, four one
// - enabled peripheral overrides general pin use except on input-only pin
// - change flag on mismatch with last read
// - pull-up off while pin is output
package sppd_pkg;

    localparam int PINS   = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PORT      = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DIR       = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ANALOG    = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CHG_EN    = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PULL_UP   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_FLAG      = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CONFIG    = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_PORT_BSET = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_PORT_BCLR = 4'h8;

    // implemented bits and reset values
    localparam logic [PINS-1:0] DIR_RESET        = 6'h3F;
    localparam logic [PINS-1:0] INPUT_ONLY_MASK  = 6'h08;
    localparam logic [PINS-1:0] OSC_PIN_MASK     = 6'h30;
    localparam logic [PINS-1:0] ANALOG_IMPL      = 6'h17;
    localparam logic [PINS-1:0] ANALOG_RESET     = 6'h17;
    localparam logic [PINS-1:0] PULL_UP_IMPL     = 6'h37;
    localparam logic [PINS-1:0] PULL_UP_RESET    = 6'h37;
    localparam logic [PINS-1:0] CHG_EN_RESET     = 6'h00;
    localparam logic [PINS-1:0] LATCH_RESET      = 6'h00;
    localparam logic [PINS-1:0] PINS_ZERO        = 6'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;
    localparam logic [DATA_W-PINS-1:0] UPPER_ZERO = 2'h0;

    // field positions
    localparam int INPUT_ONLY_BIT  = 3;
    localparam int FLAG_BIT        = 0;
    localparam int CFG_EXT_RST_BIT = 0;
    localparam int CFG_OSC_LSB     = 1;
    localparam int CFG_OSC_MSB     = 2;

    typedef enum logic [1:0]
    {
        SPPD_OSC_OTHER,
        SPPD_OSC_LOW_POWER,
        SPPD_OSC_MEDIUM_GAIN,
        SPPD_OSC_HIGH_GAIN
    } sppd_osc_t;

endpackage : sppd_pkg

//--- hw/sppd_sync.sv
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/10ps
module sppd_sync
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin_raw,
    output logic      pin_level
);

    logic stage1;
    logic stage2;
    logic stage3;
    logic next_level;

    always_comb
    begin
        next_level = pin_level;
        if (stage2 == stage3)
        begin
            next_level = stage3;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stage1    <= 1'b0;
            stage2    <= 1'b0;
            stage3    <= 1'b0;
            pin_level <= 1'b0;
        end
        else
        begin
            stage1    <= pin_raw;
            stage2    <= stage1;
            stage3    <= stage2;
            pin_level <= next_level;
        end
    end

endmodule : sppd_sync

//--- hw/sppd_port.sv
// six-pin general-purpose port: latch, direction, analog select, change flag
`timescale 1ns/10ps
module sppd_port
(
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic [sppd_pkg::ADDR_W-1:0]   addr,
    input  wire logic [sppd_pkg::DATA_W-1:0]   wdata,
    input  wire logic                          wr,
    input  wire logic                          rd,
    output logic      [sppd_pkg::DATA_W-1:0]   rdata,
    input  wire logic [sppd_pkg::PINS-1:0]     pin_in,
    output logic      [sppd_pkg::PINS-1:0]     pin_out,
    output logic      [sppd_pkg::PINS-1:0]     pin_oe,
    output logic      [sppd_pkg::PINS-1:0]     pull_up_on,
    input  wire logic [sppd_pkg::PINS-1:0]     periph_en,
    input  wire logic [sppd_pkg::PINS-1:0]     periph_out,
    input  wire logic [sppd_pkg::PINS-1:0]     periph_oe,
    output logic                               pin_change_flag
);

    // register state
    logic [sppd_pkg::PINS-1:0] output_latch;
    logic [sppd_pkg::PINS-1:0] direction_bits;
    logic [sppd_pkg::PINS-1:0] analog_select;
    logic [sppd_pkg::PINS-1:0] change_detect_enable;
    logic [sppd_pkg::PINS-1:0] pull_up_enable;
    logic [sppd_pkg::PINS-1:0] last_read;
    logic                      external_reset_enable;
    sppd_pkg::sppd_osc_t       osc_mode;

    logic [sppd_pkg::PINS-1:0] next_output_latch;
    logic [sppd_pkg::PINS-1:0] next_direction_bits;
    logic [sppd_pkg::PINS-1:0] next_analog_select;
    logic [sppd_pkg::PINS-1:0] next_change_detect_enable;
    logic [sppd_pkg::PINS-1:0] next_pull_up_enable;
    logic [sppd_pkg::PINS-1:0] next_last_read;
    logic                      next_external_reset_enable;
    sppd_pkg::sppd_osc_t       next_osc_mode;
    logic                      next_pin_change_flag;

    // pin-side outputs and read data
    logic [sppd_pkg::PINS-1:0]   next_pin_out;
    logic [sppd_pkg::PINS-1:0]   next_pin_oe;
    logic [sppd_pkg::PINS-1:0]   next_pull_up_on;
    logic [sppd_pkg::DATA_W-1:0] next_rdata;

    // derived values
    logic [sppd_pkg::PINS-1:0]   pin_level_bits;
    logic [sppd_pkg::PINS-1:0]   digital_read;
    logic [sppd_pkg::PINS-1:0]   crystal_pins;
    logic [sppd_pkg::PINS-1:0]   direction_read;
    logic [sppd_pkg::PINS-1:0]   mismatch;
    logic                        crystal_mode;
    logic                        port_access;

    // pin input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < sppd_pkg::PINS; gi++)
        begin : g_sync
            sppd_sync u_sync
            (
                .clk_sys   (clk_sys),
                .rst       (rst),
                .pin_raw   (pin_in[gi]),
                .pin_level (pin_level_bits[gi])
            );
        end
    endgenerate

    // digital view of the pins and direction read-back
    always_comb
    begin
        crystal_mode = (osc_mode != sppd_pkg::SPPD_OSC_OTHER);
        crystal_pins = crystal_mode ? sppd_pkg::OSC_PIN_MASK : sppd_pkg::PINS_ZERO;
        digital_read = pin_level_bits & ~analog_select;
        if (external_reset_enable)
        begin
            digital_read[sppd_pkg::INPUT_ONLY_BIT] = 1'b0;
        end
        direction_read = direction_bits | crystal_pins
                       | sppd_pkg::INPUT_ONLY_MASK;
        mismatch = change_detect_enable & ~analog_select
                 & (digital_read ^ last_read);
        port_access = ((rd || wr) && (addr == sppd_pkg::OFS_PORT))
                    || (wr && (addr == sppd_pkg::OFS_PORT_BSET))
                    || (wr && (addr == sppd_pkg::OFS_PORT_BCLR));
    end

    // register writes
    always_comb
    begin
        next_output_latch          = output_latch;
        next_direction_bits        = direction_bits;
        next_analog_select         = analog_select;
        next_change_detect_enable  = change_detect_enable;
        next_pull_up_enable        = pull_up_enable;
        next_external_reset_enable = external_reset_enable;
        next_osc_mode              = osc_mode;
        if (wr)
        begin
            unique case (addr)
                sppd_pkg::OFS_PORT:
                begin
                    // whole-byte write: every pin bit is modified
                    next_output_latch = wdata[sppd_pkg::PINS-1:0];
                end
                sppd_pkg::OFS_PORT_BSET:
                begin
                    next_output_latch = digital_read
                                      | wdata[sppd_pkg::PINS-1:0];
                end
                sppd_pkg::OFS_PORT_BCLR:
                begin
                    next_output_latch = digital_read
                                      & ~wdata[sppd_pkg::PINS-1:0];
                end
                sppd_pkg::OFS_DIR:
                begin
                    next_direction_bits = wdata[sppd_pkg::PINS-1:0]
                                        | sppd_pkg::INPUT_ONLY_MASK;
                end
                sppd_pkg::OFS_ANALOG:
                begin
                    next_analog_select = wdata[sppd_pkg::PINS-1:0]
                                       & sppd_pkg::ANALOG_IMPL;
                end
                sppd_pkg::OFS_CHG_EN:
                begin
                    next_change_detect_enable = wdata[sppd_pkg::PINS-1:0];
                end
                sppd_pkg::OFS_PULL_UP:
                begin
                    next_pull_up_enable = wdata[sppd_pkg::PINS-1:0]
                                        & sppd_pkg::PULL_UP_IMPL;
                end
                sppd_pkg::OFS_CONFIG:
                begin
                    next_external_reset_enable = wdata[sppd_pkg::CFG_EXT_RST_BIT];
                    next_osc_mode = sppd_pkg::sppd_osc_t'(
                        wdata[sppd_pkg::CFG_OSC_MSB:sppd_pkg::CFG_OSC_LSB]);
                end
                default:
                begin
                    next_output_latch = output_latch;
                end
            endcase
        end
    end

    // change detection: last-read latch and sticky flag, set wins over clear
    always_comb
    begin
        next_last_read       = last_read;
        next_pin_change_flag = pin_change_flag;
        // a port access re-arms the compare against the fresh pin view
        if (port_access)
        begin
            next_last_read = digital_read;
        end
        if (wr && (addr == sppd_pkg::OFS_FLAG) && wdata[sppd_pkg::FLAG_BIT])
        begin
            next_pin_change_flag = 1'b0;
        end
        if (|mismatch)
        begin
            next_pin_change_flag = 1'b1;
        end
    end

    // pin drivers and pull-ups
    always_comb
    begin
        // analog select plays no part in the drive path
        next_pin_oe  = ~direction_bits & ~crystal_pins;
        next_pin_out = output_latch;
        for (int i = 0; i < sppd_pkg::PINS; i++)
        begin
            if (periph_en[i])
            begin
                next_pin_oe[i]  = periph_oe[i];
                next_pin_out[i] = periph_out[i];
            end
        end
        next_pin_oe  = next_pin_oe & ~sppd_pkg::INPUT_ONLY_MASK;
        next_pin_out = next_pin_out & ~sppd_pkg::INPUT_ONLY_MASK;
        next_pull_up_on = pull_up_enable & ~next_pin_oe
                        & ~analog_select & ~crystal_pins;
        // input-only pin pull-up follows the external reset option
        next_pull_up_on[sppd_pkg::INPUT_ONLY_BIT] = external_reset_enable;
    end

    // read data, valid only in the cycle after the strobe
    always_comb
    begin
        next_rdata = sppd_pkg::DATA_ZERO;
        if (rd)
        begin
            unique case (addr)
                sppd_pkg::OFS_PORT:
                begin
                    next_rdata = {sppd_pkg::UPPER_ZERO, digital_read};
                end
                sppd_pkg::OFS_DIR:
                begin
                    next_rdata = {sppd_pkg::UPPER_ZERO, direction_read};
                end
                sppd_pkg::OFS_ANALOG:
                begin
                    next_rdata = {sppd_pkg::UPPER_ZERO, analog_select};
                end
                sppd_pkg::OFS_CHG_EN:
                begin
                    next_rdata = {sppd_pkg::UPPER_ZERO,
                                  change_detect_enable | crystal_pins};
                end
                sppd_pkg::OFS_PULL_UP:
                begin
                    next_rdata = {sppd_pkg::UPPER_ZERO, pull_up_enable | crystal_pins};
                end
                sppd_pkg::OFS_FLAG:
                begin
                    next_rdata[sppd_pkg::FLAG_BIT] = pin_change_flag;
                end
                sppd_pkg::OFS_CONFIG:
                begin
                    next_rdata[sppd_pkg::CFG_EXT_RST_BIT] = external_reset_enable;
                    next_rdata[sppd_pkg::CFG_OSC_MSB:sppd_pkg::CFG_OSC_LSB] = osc_mode;
                end
                default:
                begin
                    next_rdata = sppd_pkg::DATA_ZERO;
                end
            endcase
        end
    end

    // register file
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            output_latch          <= sppd_pkg::LATCH_RESET;
            direction_bits        <= sppd_pkg::DIR_RESET;
            analog_select         <= sppd_pkg::ANALOG_RESET;
            change_detect_enable  <= sppd_pkg::CHG_EN_RESET;
            pull_up_enable        <= sppd_pkg::PULL_UP_RESET;
            external_reset_enable <= 1'b0;
            osc_mode              <= sppd_pkg::SPPD_OSC_OTHER;
        end
        else
        begin
            output_latch          <= next_output_latch;
            direction_bits        <= next_direction_bits;
            analog_select         <= next_analog_select;
            change_detect_enable  <= next_change_detect_enable;
            pull_up_enable        <= next_pull_up_enable;
            external_reset_enable <= next_external_reset_enable;
            osc_mode              <= next_osc_mode;
        end
    end

    // change detection state
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            last_read             <= sppd_pkg::PINS_ZERO;
            pin_change_flag       <= 1'b0;
        end
        else
        begin
            last_read             <= next_last_read;
            pin_change_flag       <= next_pin_change_flag;
        end
    end

    // pin drivers and pull-ups
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_out               <= sppd_pkg::PINS_ZERO;
            pin_oe                <= sppd_pkg::PINS_ZERO;
            pull_up_on            <= sppd_pkg::PINS_ZERO;
        end
        else
        begin
            pin_out               <= next_pin_out;
            pin_oe                <= next_pin_oe;
            pull_up_on            <= next_pull_up_on;
        end
    end

    // read data
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata                 <= sppd_pkg::DATA_ZERO;
        end
        else
        begin
            rdata                 <= next_rdata;
        end
    end

endmodule : sppd_port

//--- sim/sppd_port_checker.sv
// concurrent checks on the six-pin port boundary
`timescale 1ns/10ps
module sppd_port_checker
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    input wire logic [5:0] pull_up_on,
    input wire logic [5:0] periph_en,
    input wire logic [5:0] periph_oe
);
    logic [5:0] dir_q;
    logic [5:0] next_dir_q;
    logic [5:0] ana_q;
    logic [5:0] next_ana_q;
    logic [2:0] cfg_q;
    logic [2:0] next_cfg_q;
    logic [5:0] dir_oe;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // shadow of direction, analog select and configuration
    always_comb
    begin
        next_dir_q = dir_q;
        next_ana_q = ana_q;
        next_cfg_q = cfg_q;
        if (wr && addr == sppd_pkg::OFS_DIR)
            next_dir_q = wdata[5:0];
        if (wr && addr == sppd_pkg::OFS_ANALOG)
            next_ana_q = wdata[5:0] & sppd_pkg::ANALOG_IMPL;
        if (wr && addr == sppd_pkg::OFS_CONFIG)
            next_cfg_q = wdata[2:0];
    end

    always_ff @(posedge clk_sys)
    begin
        dir_q <= rst ? sppd_pkg::DIR_RESET : next_dir_q;
        ana_q <= rst ? sppd_pkg::ANALOG_RESET : next_ana_q;
        cfg_q <= rst ? 3'h0 : next_cfg_q;
    end

    assign dir_oe = ~dir_q & 6'h37 & ((cfg_q[2:1] != 2'h0) ? 6'h0F : 6'h3F);

    input_only_a: assert property (!pin_oe[3] && !pin_out[3])
        else $error("input-only pin driven");
    dir_readback_a: assert property (rd && addr == sppd_pkg::OFS_DIR |=> rdata[3]
        && (cfg_q[2:1] == 2'h0 || rdata[5:4] == 2'h3)) else $error("direction read-back wrong");
    upper_zero_a: assert property (rd |=> rdata[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");
    analog_read_a: assert property (rd && addr == sppd_pkg::OFS_PORT |=>
        (rdata[5:0] & ana_q) == 6'h00) else $error("analog pin read nonzero");
    ext_reset_read_a: assert property (rd && addr == sppd_pkg::OFS_PORT && cfg_q[0]
        |=> !rdata[3]) else $error("input-only pin read nonzero");
    dir_drive_a: assert property (periph_en == 6'h00 |=> pin_oe == $past(dir_oe))
        else $error("drivers disagree with direction");
    periph_own_a: assert property (((pin_oe ^ $past(periph_oe)) & $past(periph_en)
        & 6'h37) == 6'h00) else $error("peripheral lost pin ownership");
    pull_off_a: assert property ((pull_up_on & pin_oe) == 6'h00)
        else $error("pull-up on an output pin");
endmodule : sppd_port_checker

bind sppd_port sppd_port_checker u_chk
(
    .clk_sys    (clk_sys),
    .rst        (rst),
    .addr       (addr),
    .wdata      (wdata),
    .wr         (wr),
    .rd         (rd),
    .rdata      (rdata),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .pull_up_on (pull_up_on),
    .periph_en  (periph_en),
    .periph_oe  (periph_oe)
);

//--- sim/sppd_pin_board.sv
// board model: resolves device drivers, external drivers and pull-ups
`timescale 1ns/10ps
module sppd_pin_board
(
    input  wire logic       clk_sys,
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] pull_up_on,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_val,
    output logic      [5:0] pin_in
);
    logic [5:0] last_lvl;
    always_ff @(posedge clk_sys)
        last_lvl <= pin_in;
    // floating pins flip each cycle so a stale level never looks valid
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_on | ~last_lvl));
endmodule : sppd_pin_board

//--- sim/sppd_port_tb_top.sv
// self-checking bench for the six-pin port
`timescale 1ns/10ps
module sppd_port_tb_top;
    logic       clk_sys, rst, wr, rd, pin_change_flag;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [5:0] pin_in, pin_out, pin_oe, pull_up_on, ext_en, ext_val;
    logic [5:0] periph_en, periph_out, periph_oe, m_dir, m_ana, m_lat;
    logic [2:0] m_cfg;
    int         miscompares, n_checks, cycles;

    sppd_port u_dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_on(pull_up_on), .periph_en(periph_en), .periph_out(periph_out),
        .periph_oe(periph_oe), .pin_change_flag(pin_change_flag));
    sppd_pin_board u_board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_up_on(pull_up_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic check(string what, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(logic [3:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        rv = rdata;
    endtask : rd_reg
    function automatic logic [5:0] exp_oe();
        return ~m_dir & 6'h37 & ((m_cfg[2:1] != 2'h0) ? 6'h0F : 6'h3F);
    endfunction : exp_oe
    function automatic logic [5:0] exp_port();
        logic [5:0] oe;
        oe = exp_oe();
        return ((oe & m_lat) | (~oe & ext_val)) & ~m_ana & (m_cfg[0] ? 6'h37 : 6'h3F);
    endfunction : exp_port
    task automatic check_all();
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check("pin_oe", 8'(exp_oe()), 8'(pin_oe));
        check("pin_out", 8'(exp_oe() & m_lat), 8'(pin_out & pin_oe));
        rd_reg(sppd_pkg::OFS_PORT);
        check("port", 8'(exp_port()), rv);
        rd_reg(sppd_pkg::OFS_DIR);
        check("dir", 8'(m_dir | 6'h08 | ((m_cfg[2:1] != 2'h0) ? 6'h30 : 6'h00)), rv);
    endtask : check_all
    task automatic chk_flag(logic e);
        rd_reg(sppd_pkg::OFS_FLAG);
        check("flag reg", 8'(e), rv);
        check("flag pin", 8'(e), 8'(pin_change_flag));
    endtask : chk_flag
    task automatic model_reset();
        m_dir = 6'h3F;
        m_ana = 6'h17;
        m_lat = 6'h00;
        m_cfg = 3'h0;
    endtask : model_reset

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    initial
    begin
        {rst, wr, rd, addr, wdata} = {3'b100, 4'h0, 8'h00};
        {periph_en, periph_out, periph_oe, ext_val} = 24'h000000;
        ext_en = 6'h3F;
        void'($urandom(32'h5759CD1F));
        model_reset();
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        wr_reg(4'hB, 8'hFF);
        for (int a = 1; a < 16; a++)
        begin
            if (a == 7 || a == 8)
                continue;
            rd_reg(4'(a));
            check("reset map", (a < 7) ? 8'(48'h00_00_37_00_17_3F >> (8 * (a - 1))) : 8'h00, rv);
        end
        $display("test reset_map done");
        for (int i = 0; i < 12; i++)
        begin
            rv = 8'($urandom);
            m_dir = rv[5:0];
            wr_reg(sppd_pkg::OFS_DIR, rv);
            rv = 8'($urandom);
            m_lat = rv[5:0];
            wr_reg(sppd_pkg::OFS_PORT, rv);
            m_ana = 6'($urandom) & 6'h17;
            wr_reg(sppd_pkg::OFS_ANALOG, 8'(m_ana));
            ext_val <= 6'($urandom);
            check_all();
        end
        $display("test random_dir done");
        m_dir = 6'h00;
        wr_reg(sppd_pkg::OFS_DIR, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            m_cfg = 3'(c);
            wr_reg(sppd_pkg::OFS_CONFIG, 8'(c));
            check_all();
        end
        m_cfg = 3'h0;
        wr_reg(sppd_pkg::OFS_CONFIG, 8'h00);
        $display("test config_modes done");
        m_ana = 6'h01;
        wr_reg(sppd_pkg::OFS_ANALOG, 8'h01);
        m_lat = 6'h3F;
        wr_reg(sppd_pkg::OFS_PORT, 8'h3F);
        for (int k = 0; k < 4; k++)
        begin
            check_all();
            rv = 8'($urandom);
            m_lat = k[0] ? exp_port() & ~rv[5:0] : exp_port() | rv[5:0];
            wr_reg(k[0] ? sppd_pkg::OFS_PORT_BCLR : sppd_pkg::OFS_PORT_BSET, rv);
        end
        check_all();
        $display("test read_modify_write done");
        m_ana = 6'h00;
        wr_reg(sppd_pkg::OFS_ANALOG, 8'h00);
        m_dir = 6'h3F;
        wr_reg(sppd_pkg::OFS_DIR, 8'h3F);
        ext_val <= 6'h00;
        wr_reg(sppd_pkg::OFS_CHG_EN, 8'h3F);
        check_all();
        wr_reg(sppd_pkg::OFS_FLAG, 8'h01);
        chk_flag(1'b0);
        @(posedge clk_sys);
        ext_val <= 6'h02;
        repeat (6) @(posedge clk_sys);
        chk_flag(1'b1);
        wr_reg(sppd_pkg::OFS_FLAG, 8'h01);
        chk_flag(1'b1);
        rd_reg(sppd_pkg::OFS_PORT);
        wr_reg(sppd_pkg::OFS_FLAG, 8'h01);
        chk_flag(1'b0);
        wr_reg(sppd_pkg::OFS_ANALOG, 8'h01);
        ext_val <= 6'h03;
        repeat (6) @(posedge clk_sys);
        chk_flag(1'b0);
        $display("test change_flag done");
        @(posedge clk_sys);
        {periph_en, periph_out, periph_oe} <= {6'h09, 6'h09, 6'h09};
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("periph oe", 8'h01, 8'(pin_oe));
        check("periph out", 8'h01, 8'(pin_out & pin_oe));
        @(posedge clk_sys);
        periph_en <= 6'h00;
        ext_en <= 6'h00;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("pull-up in", 8'h36, 8'(pull_up_on));
        wr_reg(sppd_pkg::OFS_DIR, 8'h00);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("pull-up out", 8'h00, 8'(pull_up_on));
        @(posedge clk_sys);
        ext_en <= 6'h3F;
        $display("test periph_pull done");
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        model_reset();
        check_all();
        $display("test mid_reset done");
        complete_run();
    end
endmodule : sppd_port_tb_top
